//--- src/bscp_pkg.sv
// Package of constants and carrier types for the boot select and code protection block
package bscp_pkg;
   // ==========================================
   // Register addresses and values
   localparam logic [7:0] ISP_CTRL_ADDR = 8'hBF;
   localparam logic [7:0] ISP_UNLOCK_ADDR = 8'hF6;
   localparam logic [7:0] UNLOCK_FIRST = 8'h87;
   localparam logic [7:0] UNLOCK_SECOND = 8'h59;
   localparam logic [15:0] SEC_BYTE_ADDR = 16'hFFFF;
   localparam logic [7:0] SEC_ERASED = 8'hFF;
   localparam logic [7:0] ISP_CTRL_RESET = 8'h08;
   localparam logic [7:0] ISP_CTRL_WMASK = 8'h9B;
   // ==========================================
   // Field positions
   localparam int CTRL_PROG_EN = 0;
   localparam int CTRL_BOOT_SEL = 1;
   localparam int CTRL_LD_RUN = 5;
   localparam int CTRL_SW_RESET = 7;
   localparam int SEC_LOCK = 1;
   localparam int SEC_TABLE_INH = 2;
   localparam int SEC_ENCRYPT = 3;
   localparam int SEC_OSC_GAIN = 7;
   localparam int STRAP_A = 0;
   localparam int STRAP_B = 1;
   localparam int STRAP_C = 2;
   // ==========================================
   // Encoding key and cycle counts
   localparam logic [7:0] ENC_KEY = 8'h5A;
   localparam int RESET_PULSE_NS = 80;
   localparam int CLK_NS = 40;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
   // ==========================================
   // Types
   typedef enum logic [1:0] {
      UNL_IDLE = 2'b00,
      UNL_GOT_FIRST = 2'b01,
      UNL_OPEN = 2'b10
   } bscp_unlock_type;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bscp_sfr_type;
   typedef struct packed {
      logic wr;
      logic rd;
      logic erase_all;
      logic [15:0] addr;
      logic [7:0] wdata;
   } bscp_prog_type;
endpackage : bscp_pkg

//--- src/bscp_sync.sv
// Two-flop synchroniser for the boot strap pins
`timescale 1ns/1ps
module bscp_sync
   import bscp_pkg::*;
(
   input wire logic clk_i,
   input wire logic [2:0] pin_i,
   output logic [2:0] sync_o
);
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   // No reset: the pins must flow through while the chip is held in reset,
   // so the boot decision at the first edge after release sees real levels
   always_ff @(posedge clk_i) begin
      meta_q <= pin_i;
      sync_q <= meta_q;
   end
   assign sync_o = sync_q;
endmodule : bscp_sync

//--- src/bscp_top.sv
// Boot source select, isp control register and security byte protection
// ==========================================
// What this block does
// - Pattern 0x83 plus idle wakeup resets to main
// - Power-on without straps boots main bank
// - Straps A,B low or C low: loader
// - Security byte at FFFF, programming mode only
// - Security bits only go one to zero
// - Lock zero blocks memory and security reads
// - Inhibit zero: external table reads stay external
// - Internal table reads always reach everything
// - Inhibit one: table reads unrestricted
// - Encryption on encodes port 0 output data
// - Only chip erase clears encryption bit
// - Bit 7 zero selects reduced oscillator gain
// - Before locking, program and verify repeatedly
// - Bits 0,1,7 set cause software reset
// - Unlock 87h then 59h; other values close
`timescale 1ns/1ps
module bscp_top
   import bscp_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [2:0] strap_pins_i,
   input wire bscp_sfr_type sfr_i,
   input wire logic idle_wakeup_i,
   input wire logic table_read_i,
   input wire logic table_from_internal_i,
   input wire logic table_addr_internal_i,
   input wire logic [7:0] port0_data_i,
   input wire logic prog_mode_i,
   input wire bscp_prog_type prog_i,
   input wire logic [7:0] code_rdata_i,
   output logic [7:0] sfr_rdata_o,
   output logic boot_loader_o,
   output logic cpu_reset_o,
   output logic table_internal_o,
   output logic [7:0] port0_out_o,
   output logic osc_low_gain_o,
   output logic code_access_ok_o,
   output logic [7:0] prog_rdata_o
);
   // ==========================================
   // State
   bscp_unlock_type unl_q;
   bscp_unlock_type unl_d;
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] sec_q;
   logic [7:0] sec_d;
   logic loader_q;
   logic loader_d;
   logic strap_taken_q;
   logic [1:0] rst_cnt_q;
   logic [1:0] rst_cnt_d;
   logic cpu_reset_q;
   logic [7:0] sfr_rdata_q;
   logic [7:0] sfr_rdata_d;
   logic table_int_q;
   logic [7:0] port0_q;
   logic osc_low_q;
   logic access_ok_q;
   logic [7:0] prog_rdata_q;
   logic [7:0] prog_rdata_d;
   logic [2:0] straps;

   // Straps are raw pins; the reset must last long enough to fill this pipeline
   bscp_sync u_sync (
      .clk_i(clk_i),
      .pin_i(strap_pins_i),
      .sync_o(straps)
   );

   function automatic logic [7:0] encode_byte(input logic [7:0] d);
      encode_byte = {d[0], d[7:1]} ^ ENC_KEY;
   endfunction : encode_byte

   // ==========================================
   // Decode
   wire ctrl_sel = sfr_i.addr == ISP_CTRL_ADDR;
   wire unl_sel = sfr_i.addr == ISP_UNLOCK_ADDR;
   wire unl_wr = sfr_i.wr && unl_sel;
   wire ctrl_wr = sfr_i.wr && ctrl_sel && (unl_q == UNL_OPEN);
   wire sw_reset_armed = ctrl_q[CTRL_SW_RESET] && ctrl_q[CTRL_BOOT_SEL]
                         && ctrl_q[CTRL_PROG_EN];
   wire sw_reset_fire = sw_reset_armed && idle_wakeup_i;
   wire strap_reboot = (!straps[STRAP_A] && !straps[STRAP_B]) || !straps[STRAP_C];
   wire locked = !sec_q[SEC_LOCK];
   wire sec_hit = prog_mode_i && (prog_i.addr == SEC_BYTE_ADDR);
   wire sec_wr = sec_hit && prog_i.wr && !locked;
   wire code_rd = prog_mode_i && prog_i.rd && !sec_hit && !locked;

   // ==========================================
   // Unlock sequence
   always_comb begin
      unl_d = unl_q;
      if (unl_wr) begin
         case (unl_q)
            UNL_IDLE: unl_d = (sfr_i.wdata == UNLOCK_FIRST) ? UNL_GOT_FIRST : UNL_IDLE;
            UNL_GOT_FIRST: unl_d = (sfr_i.wdata == UNLOCK_SECOND) ? UNL_OPEN : UNL_IDLE;
            UNL_OPEN: unl_d = (sfr_i.wdata == UNLOCK_FIRST) ? UNL_GOT_FIRST : UNL_IDLE;
            default: unl_d = UNL_IDLE;
         endcase
      end
   end

   assign ctrl_d = ctrl_wr ? ((sfr_i.wdata & ISP_CTRL_WMASK) | ISP_CTRL_RESET) : ctrl_q;

   // Security bits may only be driven low; erase-all restores ones
   assign sec_d = (prog_mode_i && prog_i.erase_all) ? SEC_ERASED
                  : sec_wr ? (sec_q & prog_i.wdata) : sec_q;

   // Software reset always returns to the main bank; straps only count at the first edge after a hardware reset
   assign loader_d = sw_reset_fire ? 1'b0 : (!strap_taken_q ? strap_reboot : loader_q);

   assign rst_cnt_d = sw_reset_fire ? 2'(RESET_PULSE_CYC) : (rst_cnt_q != 2'h0 ? rst_cnt_q - 2'h1 : 2'h0);

   assign sfr_rdata_d = !sfr_i.rd ? sfr_rdata_q
                        : ctrl_sel ? (ctrl_q | (8'(loader_q) << CTRL_LD_RUN))
                        : 8'h00;

   assign prog_rdata_d = (sec_hit && prog_i.rd && !locked) ? sec_q
                         : code_rd ? code_rdata_i : prog_rdata_q;

   // Internal code reached when fetched internally or inhibit is open
   wire table_int_d = table_read_i && table_addr_internal_i
                      && (table_from_internal_i || sec_q[SEC_TABLE_INH]);

   // ==========================================
   // Unlock state and isp control register
   // Soft reset clears the isp registers but keeps the non-volatile byte
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         unl_q <= UNL_IDLE;
         ctrl_q <= ISP_CTRL_RESET;
      end else begin
         unl_q <= sw_reset_fire ? UNL_IDLE : unl_d;
         ctrl_q <= sw_reset_fire ? ISP_CTRL_RESET : ctrl_d;
      end
   end

   // ==========================================
   // Security byte
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         sec_q <= SEC_ERASED;
      end else begin
         sec_q <= sec_d;
      end
   end

   // ==========================================
   // Boot source, taken from the straps once after a hardware reset and forced to main by a software reset
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         loader_q <= 1'b0;
         strap_taken_q <= 1'b0;
      end else begin
         loader_q <= loader_d;
         strap_taken_q <= 1'b1;
      end
   end

   // ==========================================
   // CPU reset request
   // Held through the first edge after release so the boot source settles first
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rst_cnt_q <= 2'h0;
         cpu_reset_q <= 1'b1;
      end else begin
         rst_cnt_q <= rst_cnt_d;
         cpu_reset_q <= !strap_taken_q || sw_reset_fire || (rst_cnt_q > 2'h1);
      end
   end

   // ==========================================
   // Read data
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         sfr_rdata_q <= 8'h00;
         prog_rdata_q <= 8'h00;
      end else begin
         sfr_rdata_q <= sfr_rdata_d;
         prog_rdata_q <= prog_rdata_d;
      end
   end

   // ==========================================
   // Table read gate
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         table_int_q <= 1'b0;
      end else begin
         table_int_q <= table_int_d;
      end
   end

   // ==========================================
   // Port 0 data and oscillator gain
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         port0_q <= 8'h00;
         osc_low_q <= 1'b0;
      end else begin
         port0_q <= !sec_q[SEC_ENCRYPT] ? encode_byte(port0_data_i) : port0_data_i;
         osc_low_q <= !sec_q[SEC_OSC_GAIN];
      end
   end

   // ==========================================
   // Access status
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         access_ok_q <= 1'b1;
      end else begin
         access_ok_q <= !locked;
      end
   end

   assign sfr_rdata_o = sfr_rdata_q;
   assign boot_loader_o = loader_q;
   assign cpu_reset_o = cpu_reset_q;
   assign table_internal_o = table_int_q;
   assign port0_out_o = port0_q;
   assign osc_low_gain_o = osc_low_q;
   assign code_access_ok_o = access_ok_q;
   assign prog_rdata_o = prog_rdata_q;
endmodule : bscp_top

//--- verif/bscp_code_mem.sv
// Code memory model behind the programmer read path
`timescale 1ns/1ps
module bscp_code_mem (
   input wire logic [15:0] addr_i,
   output logic [7:0] rdata_o
);
   // Content derived from the address so every verify read is predictable
   assign rdata_o = addr_i[7:0] ^ addr_i[15:8] ^ 8'h3C;
endmodule : bscp_code_mem

//--- verif/bscp_props.sv
// Port-level assertions for the boot select and code protection block
`timescale 1ns/1ps
module bscp_props
   import bscp_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic idle_wakeup_i,
   input wire logic table_read_i,
   input wire logic table_from_internal_i,
   input wire logic table_addr_internal_i,
   input wire logic prog_mode_i,
   input wire bscp_sfr_type sfr_i,
   input wire bscp_prog_type prog_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic boot_loader_o,
   input wire logic cpu_reset_o,
   input wire logic table_internal_o,
   input wire logic osc_low_gain_o,
   input wire logic code_access_ok_o,
   input wire logic [7:0] prog_rdata_o
);
   // ==========================================
   // Properties
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   AST_SWRST_CAUSE: assert property ($rose(cpu_reset_o) |-> $past(idle_wakeup_i) && !boot_loader_o)
      else $error("cpu reset without wakeup");
   AST_SWRST_LEN: assert property ($rose(cpu_reset_o) |-> cpu_reset_o [*2] ##1 !cpu_reset_o)
      else $error("cpu reset length wrong");
   AST_TBL_INT: assert property (table_read_i && table_addr_internal_i && table_from_internal_i |=>
      table_internal_o) else $error("internal table read blocked");
   AST_TBL_OFF: assert property (!table_read_i |=> !table_internal_o)
      else $error("table gate open without a read");
   AST_TBL_EXT: assert property (!table_addr_internal_i |=> !table_internal_o)
      else $error("external address gave internal code");
   AST_CTRL_RD: assert property (sfr_i.rd && sfr_i.addr == ISP_CTRL_ADDR |=>
      sfr_rdata_o[3] && sfr_rdata_o[CTRL_LD_RUN] == boot_loader_o) else $error("control read wrong");
   AST_LOCKED: assert property (!code_access_ok_o && prog_i.rd |=> $stable(prog_rdata_o))
      else $error("locked read answered");
   AST_SEC_GATE: assert property (prog_i.rd && !prog_mode_i |=> $stable(prog_rdata_o))
      else $error("read outside programming mode");
   AST_GAIN: assert property ($fell(osc_low_gain_o) |-> $past(prog_i.erase_all) || $past(prog_i.erase_all, 2))
      else $error("gain bit restored without erase");
endmodule : bscp_props
bind bscp_top bscp_props i_props (.clk_i, .reset_n_i, .idle_wakeup_i, .table_read_i, .table_from_internal_i,
   .table_addr_internal_i, .prog_mode_i, .sfr_i, .prog_i, .sfr_rdata_o, .boot_loader_o, .cpu_reset_o,
   .table_internal_o, .osc_low_gain_o, .code_access_ok_o, .prog_rdata_o);

//--- verif/tb.sv
// Self-checking bench for the boot select and code protection block
`timescale 1ns/1ps
module tb
   import bscp_pkg::*;
;
   logic clk_i = 0, reset_n_i = 0, wake = 0, tfi = 0, tai = 0, pmode = 0, trd = 0;
   logic [2:0] strap = 3'h7;
   logic [7:0] p0 = 8'hC5, crd, srd, p0o, prd;
   logic boot, cres, tint, lowg, aok;
   bscp_sfr_type sfr = '0;
   bscp_prog_type prog = '0;
   int miscompares = 0, n_checks = 0;
   bscp_code_mem i_mem (.addr_i(prog.addr), .rdata_o(crd));
   bscp_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .strap_pins_i(strap), .sfr_i(sfr),
      .idle_wakeup_i(wake), .table_read_i(trd), .table_from_internal_i(tfi), .table_addr_internal_i(tai),
      .port0_data_i(p0), .prog_mode_i(pmode), .prog_i(prog), .code_rdata_i(crd), .sfr_rdata_o(srd),
      .boot_loader_o(boot), .cpu_reset_o(cres), .table_internal_o(tint), .port0_out_o(p0o),
      .osc_low_gain_o(lowg), .code_access_ok_o(aok), .prog_rdata_o(prd));
   always #20 clk_i = ~clk_i;
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic sfr_op(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      sfr = '{w, !w, a, d};
      @(negedge clk_i);
      sfr = '0;
   endtask : sfr_op
   task automatic prog_op(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_i);
      prog = '{op[2], op[1], op[0], a, d};
      @(negedge clk_i);
      prog = '0;
   endtask : prog_op
   task automatic rst(input logic [2:0] s);
      @(negedge clk_i);
      strap = s;
      reset_n_i = 0;
      repeat (5) @(negedge clk_i);
      reset_n_i = 1;
      @(negedge clk_i);
      chk(cres, 1);
      @(negedge clk_i);
      chk(cres, 0);
      chk(boot, (!s[0] && !s[1]) || !s[2]);
   endtask : rst
   task automatic t_table(input logic inh);
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_i);
         tfi = i[0];
         tai = i[1];
         trd = !i[2];
         @(negedge clk_i);
         chk(tint, trd & tai & (tfi | inh));
      end
   endtask : t_table
   // ==========================================
   // Scenarios
   task automatic t_swreset;
      sfr_op(1, ISP_UNLOCK_ADDR, UNLOCK_FIRST);
      sfr_op(1, ISP_UNLOCK_ADDR, 8'h00);
      sfr_op(1, ISP_CTRL_ADDR, 8'h83);
      sfr_op(0, ISP_CTRL_ADDR, 8'h00);
      chk(srd, 8'h28);
      sfr_op(1, ISP_UNLOCK_ADDR, UNLOCK_FIRST);
      sfr_op(1, ISP_UNLOCK_ADDR, UNLOCK_SECOND);
      sfr_op(1, ISP_CTRL_ADDR, 8'h83);
      sfr_op(0, ISP_CTRL_ADDR, 8'h00);
      chk(srd, 8'hAB);
      @(negedge clk_i);
      wake = 1;
      @(negedge clk_i);
      wake = 0;
      chk(cres, 1);
      chk(boot, 0);
      @(negedge clk_i);
      chk(cres, 1);
      @(negedge clk_i);
      chk(cres, 0);
      sfr_op(0, ISP_CTRL_ADDR, 8'h00);
      chk(srd, 8'h08);
      sfr_op(0, 8'h00, 8'h00);
      chk(srd, 8'h00);
      $display("t_swreset done");
   endtask : t_swreset
   task automatic t_sec;
      t_table(1);
      pmode = 1;
      prog_op(3'h2, SEC_BYTE_ADDR, 8'h00);
      chk(prd, SEC_ERASED);
      chk(p0o, p0);
      prog_op(3'h4, SEC_BYTE_ADDR, 8'h77);
      // Writing ones back must not restore cleared bits
      prog_op(3'h4, SEC_BYTE_ADDR, 8'hFF);
      prog_op(3'h2, SEC_BYTE_ADDR, 8'h00);
      chk(prd, 8'h77);
      chk(lowg, 1);
      chk(p0o, {p0[0], p0[7:1]} ^ ENC_KEY);
      repeat (2) prog_op(3'h2, 16'h1234, 8'h00);
      chk(prd, 8'h1A);
      pmode = 0;
      prog_op(3'h2, SEC_BYTE_ADDR, 8'h00);
      chk(prd, 8'h1A);
      t_table(1);
      pmode = 1;
      prog_op(3'h4, SEC_BYTE_ADDR, 8'hFB);
      t_table(0);
      prog_op(3'h4, SEC_BYTE_ADDR, 8'hFD);
      prog_op(3'h2, 16'h5678, 8'h00);
      chk(prd, 8'h1A);
      chk(aok, 0);
      prog_op(3'h1, 16'h0000, 8'h00);
      prog_op(3'h2, SEC_BYTE_ADDR, 8'h00);
      chk(prd, SEC_ERASED);
      chk(aok, 1);
      chk(lowg, 0);
      chk(p0o, p0);
      $display("t_sec done");
   endtask : t_sec
   task automatic end_of_test;
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #400000;
      miscompares++;
      end_of_test();
   end
   initial begin
      for (int i = 7; i >= 0; i--) rst(i[2:0]);
      $display("t_boot done");
      t_swreset();
      t_sec();
      end_of_test();
   end
endmodule : tb
